// ### logic/psilc_pkg.sv
// Notes on behaviour
// R1 - select pin high: serial control, else straps
// R2 - select pin low resets serial controller asynchronously
// R3 - system holds deskew enable high in serial mode
// R4 - bus select high 24-bit, low 12-bit halves
// R5 - dual edge: both edges of positive clock
// R6 - 12-bit single edge: halves on pos/neg clocks
// R7 - system keeps dual edge low in 24-bit
// R8 - serial mode: edge pin is undebounced hot plug; code takes it through the pin synchroniser
// R9 - dual edge primary edge set by edge select
// R10 - dual edge: syncs sampled on secondary edge only
// R11 - single edge: edge select picks latch polarity
// R12 - straps, deskew enable low: default, general inputs
// R13 - straps, deskew enable high: deskew from pins
// R14 - serial mode: deskew from programmed value
// R15 - serial, enable high: pins give address bits
// R16 - source drives valid only with valid pixels
// R17 - 12-bit mode: syncs latched on secondary edge
// R18 - straps change only while device held reset
package psilc_pkg;
   localparam logic [3:0] REG_MODE_CTRL = 4'h0;
   localparam logic [3:0] REG_DESKEW_CTRL = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_FLAGS = 4'h3;
   localparam int MODE_EDGE_BIT = 0;
   localparam int MODE_BUS24_BIT = 1;
   localparam int MODE_DUAL_BIT = 2;
   localparam logic [2:0] MODE_CTRL_RESET = 3'h0;
   localparam logic [2:0] DESKEW_CTRL_RESET = 3'h0;
   localparam logic [2:0] DESKEW_DEFAULT = 3'h0;
   localparam int FLAG_OVERFLOW_BIT = 0;
   localparam int FLAG_CONFIG_BIT = 1;
   localparam int SYNC_STAGES = 3;
   localparam int FIFO_DEPTH = 4;
   localparam int WORD_W = 27;
   typedef enum logic [1:0] {
      ST_WAIT_FIRST = 2'b01,
      ST_WAIT_SECOND = 2'b10
   } psilc_cap_t;
endpackage

// ### logic/psilc_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; level moves only when stages two and three agree
module psilc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] lvl
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         lvl <= '0;
      end else begin
         lvl <= (s2_r & s3_r) | (lvl & (s2_r | s3_r));
      end
   end
endmodule

// ### logic/psilc_fifo.sv
`timescale 1ns/1ps
// small fifo with a registered output stage
module psilc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   logic empty;
   logic full;
   logic do_wr;
   logic do_rd;
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
   assign in_ready = !full;
   assign do_wr = in_valid && !full;
   assign do_rd = !empty && (!out_valid || out_ready);
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (do_rd) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr_r[AW-1:0]];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule

// ### logic/psilc_top.sv
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module psilc_top #(
   parameter int FIFO_DEPTH = psilc_pkg::FIFO_DEPTH
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic SERIAL_IF_SELECT,
   input wire logic BUS_WIDTH_SELECT,
   input wire logic DUAL_EDGE_SELECT,
   input wire logic EDGE_SELECT,
   input wire logic DESKEW_PIN_ENABLE,
   input wire logic [2:0] DESKEW_SETTING_PINS,
   input wire logic PIXEL_CLOCK_POS,
   input wire logic PIXEL_CLOCK_NEG,
   input wire logic PIXEL_VALID,
   input wire logic HSYNC,
   input wire logic VSYNC,
   input wire logic [23:0] PIXEL_DATA,
   input wire logic [3:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic SERIAL_IF_ENABLE,
   output logic SERIAL_CTRL_RESET_N,
   output logic SERIAL_SCL,
   output logic SERIAL_SDA,
   output logic HOT_PLUG_DETECT,
   output logic [2:0] GENERAL_PURPOSE_INPUTS,
   output logic [2:0] SLAVE_ADDR_LOW,
   output logic [2:0] DESKEW_VALUE,
   output logic MODE_24BIT,
   output logic MODE_DUAL_EDGE,
   output logic EDGE_RISING,
   output logic WORD_VALID,
   input wire logic WORD_READY,
   output logic [23:0] WORD_DATA,
   output logic WORD_HSYNC,
   output logic WORD_VSYNC,
   output logic WORD_DE
);
   localparam int PIN_W = 8;
   localparam int BUS_W = 29;
   logic [PIN_W-1:0] pin_lvl;
   logic [BUS_W-1:0] bus_lvl;
   logic sel_l;
   logic bus_width_select_l;
   logic dual_edge_select_l;
   logic edge_l;
   logic deskew_pin_enable_l;
   logic [2:0] dk_l;
   logic pos_l;
   logic neg_l;
   logic de_l;
   logic hs_l;
   logic vs_l;
   logic [23:0] data_l;
   logic pos_prev_r;
   logic neg_prev_r;
   logic pos_rise;
   logic pos_fall;
   logic neg_rise;
   logic neg_fall;
   logic [2:0] mode_ctrl_r;
   logic [2:0] deskew_ctrl_r;
   logic overflow_r;
   logic config_err_r;
   logic serial_en;
   logic bus24;
   logic dual;
   logic rising;
   logic prim_ev;
   logic sec_ev;
   psilc_pkg::psilc_cap_t state_r;
   logic [11:0] first_half_r;
   logic push_r;
   logic [psilc_pkg::WORD_W-1:0] push_data_r;
   logic fifo_in_ready;
   logic [psilc_pkg::WORD_W-1:0] fifo_out_data;
   logic wr_hit;
   logic [7:0] rd_mux;

   function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
         input logic [3:0] target);
      return strobe && (addr == target);
   endfunction
   function automatic logic pick_edge(input logic want_rise, input logic rise_ev,
         input logic fall_ev);
      return want_rise ? rise_ev : fall_ev;
   endfunction

   psilc_sync #(.W(PIN_W)) u_pin_sync (
      .clk(CLK_SYS),
      .rst(RST),
      .din({DESKEW_SETTING_PINS, DESKEW_PIN_ENABLE, EDGE_SELECT, DUAL_EDGE_SELECT,
            BUS_WIDTH_SELECT, SERIAL_IF_SELECT}),
      .lvl(pin_lvl)
   );
   psilc_sync #(.W(BUS_W)) u_bus_sync (
      .clk(CLK_SYS),
      .rst(RST),
      .din({PIXEL_CLOCK_NEG, PIXEL_CLOCK_POS, PIXEL_VALID, VSYNC, HSYNC, PIXEL_DATA}),
      .lvl(bus_lvl)
   );
   assign sel_l = pin_lvl[0];
   assign bus_width_select_l = pin_lvl[1];
   assign dual_edge_select_l = pin_lvl[2];
   assign edge_l = pin_lvl[3];
   assign deskew_pin_enable_l = pin_lvl[4];
   assign dk_l = pin_lvl[7:5];
   assign data_l = bus_lvl[23:0];
   assign hs_l = bus_lvl[24];
   assign vs_l = bus_lvl[25];
   assign de_l = bus_lvl[26];
   assign pos_l = bus_lvl[27];
   assign neg_l = bus_lvl[28];

   // serial reset asserts straight from the pin, releases on the synced level
   always_ff @(posedge CLK_SYS or negedge SERIAL_IF_SELECT) begin
      if (!SERIAL_IF_SELECT) begin
         SERIAL_CTRL_RESET_N <= 1'b0; // [R2]
      end else if (RST) begin
         SERIAL_CTRL_RESET_N <= 1'b0;
      end else begin
         SERIAL_CTRL_RESET_N <= sel_l; // [R2]
      end
   end

   // mode source: programmed bits in serial mode, strap levels otherwise
   assign serial_en = sel_l; // [R1]
   assign bus24 = serial_en ? mode_ctrl_r[psilc_pkg::MODE_BUS24_BIT] : bus_width_select_l; // [R1] [R4]
   assign dual = serial_en ? mode_ctrl_r[psilc_pkg::MODE_DUAL_BIT] : dual_edge_select_l; // [R5]
   assign rising = serial_en ? mode_ctrl_r[psilc_pkg::MODE_EDGE_BIT] : edge_l;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         SERIAL_IF_ENABLE <= 1'b0;
         SERIAL_SCL <= 1'b0;
         SERIAL_SDA <= 1'b0;
         HOT_PLUG_DETECT <= 1'b0;
         MODE_24BIT <= 1'b0;
         MODE_DUAL_EDGE <= 1'b0;
         EDGE_RISING <= 1'b0;
      end else begin
         SERIAL_IF_ENABLE <= serial_en; // [R1]
         SERIAL_SCL <= serial_en & bus_width_select_l;
         SERIAL_SDA <= serial_en & dual_edge_select_l;
         HOT_PLUG_DETECT <= serial_en & edge_l; // [R8]
         MODE_24BIT <= bus24; // [R4]
         MODE_DUAL_EDGE <= dual & !bus24; // [R7]
         EDGE_RISING <= rising;
      end
   end

   // deskew, address and general inputs share the three pins
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         DESKEW_VALUE <= psilc_pkg::DESKEW_DEFAULT;
         GENERAL_PURPOSE_INPUTS <= 3'h0;
         SLAVE_ADDR_LOW <= 3'h0;
      end else if (serial_en) begin
         DESKEW_VALUE <= deskew_ctrl_r; // [R14]
         GENERAL_PURPOSE_INPUTS <= 3'h0;
         SLAVE_ADDR_LOW <= deskew_pin_enable_l ? dk_l : 3'h0; // [R15]
      end else if (deskew_pin_enable_l) begin
         DESKEW_VALUE <= dk_l; // [R13]
         GENERAL_PURPOSE_INPUTS <= 3'h0;
         SLAVE_ADDR_LOW <= 3'h0;
      end else begin
         DESKEW_VALUE <= psilc_pkg::DESKEW_DEFAULT; // [R12]
         GENERAL_PURPOSE_INPUTS <= dk_l; // [R12]
         SLAVE_ADDR_LOW <= 3'h0;
      end
   end

   // clock edges seen on the filtered levels
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pos_prev_r <= 1'b0;
         neg_prev_r <= 1'b0;
      end else begin
         pos_prev_r <= pos_l;
         neg_prev_r <= neg_l;
      end
   end
   assign pos_rise = pos_l & !pos_prev_r;
   assign pos_fall = !pos_l & pos_prev_r;
   assign neg_rise = neg_l & !neg_prev_r;
   assign neg_fall = !neg_l & neg_prev_r;

   always_comb begin
      prim_ev = pick_edge(rising, pos_rise, pos_fall); // [R9] [R11]
      if (bus24) begin
         sec_ev = 1'b0;
      end else if (dual) begin
         sec_ev = pick_edge(rising, pos_fall, pos_rise); // [R5] [R9]
      end else begin
         sec_ev = pick_edge(rising, neg_rise, neg_fall); // [R6] [R11]
      end
   end

   // capture sequencer: one edge per word in 24-bit, two halves in 12-bit
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_r <= psilc_pkg::ST_WAIT_FIRST;
         first_half_r <= 12'h000;
         push_r <= 1'b0;
         push_data_r <= '0;
      end else begin
         push_r <= 1'b0;
         case (state_r)
            psilc_pkg::ST_WAIT_FIRST: begin
               if (prim_ev && bus24) begin
                  push_r <= 1'b1; // [R4] [R11]
                  push_data_r <= {de_l, vs_l, hs_l, data_l};
               end else if (prim_ev) begin
                  first_half_r <= data_l[11:0]; // [R6] [R9]
                  state_r <= psilc_pkg::ST_WAIT_SECOND;
               end
            end
            psilc_pkg::ST_WAIT_SECOND: begin
               if (bus24) begin
                  state_r <= psilc_pkg::ST_WAIT_FIRST;
               end else if (sec_ev) begin
                  // syncs only taken on the second half
                  push_r <= 1'b1;
                  push_data_r <= {de_l, vs_l, hs_l, data_l[11:0], first_half_r}; // [R10] [R17]
                  state_r <= psilc_pkg::ST_WAIT_FIRST;
               end else if (prim_ev) begin
                  first_half_r <= data_l[11:0];
               end
            end
            default: begin
               state_r <= psilc_pkg::ST_WAIT_FIRST;
            end
         endcase
      end
   end

   psilc_fifo #(.W(psilc_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(push_r),
      .in_ready(fifo_in_ready),
      .in_data(push_data_r),
      .out_valid(WORD_VALID),
      .out_ready(WORD_READY),
      .out_data(fifo_out_data)
   );
   assign WORD_DATA = fifo_out_data[23:0];
   assign WORD_HSYNC = fifo_out_data[24];
   assign WORD_VSYNC = fifo_out_data[25];
   assign WORD_DE = fifo_out_data[26];

   // register port
   assign wr_hit = reg_hit(REG_WR, REG_ADDR, psilc_pkg::REG_MODE_CTRL);
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_ctrl_r <= psilc_pkg::MODE_CTRL_RESET;
      end else if (wr_hit) begin
         mode_ctrl_r <= REG_WDATA[2:0];
      end
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         deskew_ctrl_r <= psilc_pkg::DESKEW_CTRL_RESET;
      end else if (reg_hit(REG_WR, REG_ADDR, psilc_pkg::REG_DESKEW_CTRL)) begin
         deskew_ctrl_r <= REG_WDATA[2:0]; // [R14]
      end
   end

   // sticky flags, write one to clear, a new event wins
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         overflow_r <= 1'b0;
         config_err_r <= 1'b0;
      end else begin
         if (push_r && !fifo_in_ready) begin
            overflow_r <= 1'b1;
         end else if (reg_hit(REG_WR, REG_ADDR, psilc_pkg::REG_FLAGS) &&
                      REG_WDATA[psilc_pkg::FLAG_OVERFLOW_BIT]) begin
            overflow_r <= 1'b0;
         end
         if ((serial_en && !deskew_pin_enable_l) || (bus24 && dual)) begin
            config_err_r <= 1'b1; // [R3] [R7]
         end else if (reg_hit(REG_WR, REG_ADDR, psilc_pkg::REG_FLAGS) &&
                      REG_WDATA[psilc_pkg::FLAG_CONFIG_BIT]) begin
            config_err_r <= 1'b0;
         end
      end
   end

   always_comb begin
      case (REG_ADDR)
         psilc_pkg::REG_MODE_CTRL: rd_mux = {5'h00, mode_ctrl_r};
         psilc_pkg::REG_DESKEW_CTRL: rd_mux = {5'h00, deskew_ctrl_r};
         psilc_pkg::REG_STATUS: rd_mux = {2'h0, deskew_pin_enable_l, HOT_PLUG_DETECT, EDGE_RISING,
                                          MODE_DUAL_EDGE, MODE_24BIT, SERIAL_IF_ENABLE};
         psilc_pkg::REG_FLAGS: rd_mux = {6'h00, config_err_r, overflow_r};
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= rd_mux;
      end else begin
         REG_RDATA <= 8'h00;
      end
   end
endmodule

// ### dv/psilc_properties.sv
`timescale 1ns/1ps
module psilc_props (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic SERIAL_IF_SELECT,
   input wire logic BUS_WIDTH_SELECT,
   input wire logic DUAL_EDGE_SELECT,
   input wire logic EDGE_SELECT,
   input wire logic DESKEW_PIN_ENABLE,
   input wire logic [2:0] DESKEW_SETTING_PINS,
   input wire logic SERIAL_IF_ENABLE,
   input wire logic SERIAL_CTRL_RESET_N,
   input wire logic HOT_PLUG_DETECT,
   input wire logic [2:0] GENERAL_PURPOSE_INPUTS,
   input wire logic [2:0] SLAVE_ADDR_LOW,
   input wire logic [2:0] DESKEW_VALUE,
   input wire logic MODE_24BIT,
   input wire logic MODE_DUAL_EDGE,
   input wire logic EDGE_RISING
);
   wire logic [7:0] pins_w = {SERIAL_IF_SELECT, BUS_WIDTH_SELECT, DUAL_EDGE_SELECT, EDGE_SELECT,
      DESKEW_PIN_ENABLE, DESKEW_SETTING_PINS};
   wire logic [2:0] dk_w = DESKEW_PIN_ENABLE ? DESKEW_SETTING_PINS : 3'h0;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // pins held long enough to pass the synchronisers
   sequence s_strap;
      (!SERIAL_IF_SELECT && $stable(pins_w)) [*7];
   endsequence
   sequence s_serial;
      (SERIAL_IF_SELECT && $stable(pins_w)) [*7];
   endsequence
   property p_ctrl_reset; !SERIAL_IF_SELECT |-> !SERIAL_CTRL_RESET_N; endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("ctrl reset");
   property p_serial_on; s_serial |-> SERIAL_IF_ENABLE && SERIAL_CTRL_RESET_N; endproperty
   a_serial_on: assert property (p_serial_on) else $error("serial on");
   property p_strap_off; s_strap |-> !SERIAL_IF_ENABLE && SLAVE_ADDR_LOW == 3'h0; endproperty
   a_strap_off: assert property (p_strap_off) else $error("strap off");
   property p_width; s_strap |-> MODE_24BIT == BUS_WIDTH_SELECT; endproperty
   a_width: assert property (p_width) else $error("width");
   property p_edge; s_strap |-> EDGE_RISING == EDGE_SELECT; endproperty
   a_edge: assert property (p_edge) else $error("edge");
   property p_dual; s_strap |-> MODE_DUAL_EDGE == (DUAL_EDGE_SELECT && !BUS_WIDTH_SELECT); endproperty
   a_dual: assert property (p_dual) else $error("dual");
   property p_gpi; s_strap |-> GENERAL_PURPOSE_INPUTS == (DESKEW_SETTING_PINS ^ dk_w); endproperty
   a_gpi: assert property (p_gpi) else $error("gpi");
   property p_deskew; s_strap |-> DESKEW_VALUE == dk_w; endproperty
   a_deskew: assert property (p_deskew) else $error("deskew");
   property p_hotplug; s_serial |-> HOT_PLUG_DETECT == EDGE_SELECT; endproperty
   a_hotplug: assert property (p_hotplug) else $error("hot plug");
   property p_addr; s_serial |-> SLAVE_ADDR_LOW == dk_w && GENERAL_PURPOSE_INPUTS == 3'h0; endproperty
   a_addr: assert property (p_addr) else $error("addr");
endmodule
bind psilc_top psilc_props psilc_props_inst (.*);

// ### dv/psilc_gfx_src.sv
`timescale 1ns/1ps
module psilc_gfx_src (
   input wire logic clk,
   output logic clk_pos,
   output logic clk_neg,
   output logic valid,
   output logic hs,
   output logic vs,
   output logic [23:0] data
);
   initial begin
      {clk_pos, clk_neg, valid, hs, vs, data} = 29'h0;
   end
   // one clock edge, bus set up and held four cycles around it
   task automatic edge_out(input logic neg, input logic [23:0] d, input logic de, input logic h,
      input logic v);
      @(posedge clk);
      data <= d;
      valid <= de;
      hs <= h;
      vs <= v;
      repeat (4) @(posedge clk);
      if (neg) clk_neg <= ~clk_neg;
      else clk_pos <= ~clk_pos;
      repeat (4) @(posedge clk);
      data <= ~d;
   endtask
endmodule

// ### dv/psilc_top_test.sv
`timescale 1ns/1ps
module psilc_top_test;
   logic CLK_SYS, RST, SERIAL_IF_SELECT, BUS_WIDTH_SELECT, DUAL_EDGE_SELECT, EDGE_SELECT;
   logic DESKEW_PIN_ENABLE, PIXEL_CLOCK_POS, PIXEL_CLOCK_NEG, PIXEL_VALID, HSYNC, VSYNC;
   logic REG_WR, REG_RD, SERIAL_IF_ENABLE, SERIAL_CTRL_RESET_N, SERIAL_SCL, SERIAL_SDA;
   logic HOT_PLUG_DETECT, MODE_24BIT, MODE_DUAL_EDGE, EDGE_RISING, WORD_VALID, WORD_READY;
   logic WORD_HSYNC, WORD_VSYNC, WORD_DE;
   logic [2:0] DESKEW_SETTING_PINS, GENERAL_PURPOSE_INPUTS, SLAVE_ADDR_LOW, DESKEW_VALUE;
   logic [23:0] PIXEL_DATA, WORD_DATA;
   logic [3:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA;
   logic [26:0] exp_q[$];
   logic [15:0] lfsr;
   logic [7:0] tab [6] = '{8'h55, 8'h4B, 8'h3E, 8'h12, 8'hDE, 8'hA9};
   int mismatches, n_tests, i, j;
   psilc_top psilc_top_inst (.*);
   psilc_gfx_src psilc_gfx_src_inst (.clk(CLK_SYS), .clk_pos(PIXEL_CLOCK_POS),
      .clk_neg(PIXEL_CLOCK_NEG), .valid(PIXEL_VALID), .hs(HSYNC), .vs(VSYNC), .data(PIXEL_DATA));
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [26:0] e, input logic [26:0] s);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge CLK_SYS);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1;
      chk("rdata", 27'(e), 27'(REG_RDATA));
   endtask
   // straps change under reset, then settle
   task automatic cfg(input logic [7:0] p);
      logic s, b, u, e, k;
      logic [2:0] q;
      logic [15:0] x;
      {s, b, u, e, k, q} = p;
      if (s) x = {4'h8, b, u, e, 3'h0, k ? q : 3'h0, psilc_pkg::DESKEW_CTRL_RESET};
      else x = {1'b0, b, u & ~b, e, 3'h0, k ? 3'h0 : q, 3'h0, k ? q : psilc_pkg::DESKEW_DEFAULT};
      @(posedge CLK_SYS);
      RST <= 1'b1;
      {SERIAL_IF_SELECT, BUS_WIDTH_SELECT, DUAL_EDGE_SELECT, EDGE_SELECT, DESKEW_PIN_ENABLE,
         DESKEW_SETTING_PINS} <= p;
      repeat (4) @(posedge CLK_SYS);
      RST <= 1'b0;
      repeat (10) @(posedge CLK_SYS);
      chk("config", 27'(x), 27'({SERIAL_IF_ENABLE, MODE_24BIT, MODE_DUAL_EDGE, EDGE_RISING,
         SERIAL_SCL, SERIAL_SDA, HOT_PLUG_DETECT, GENERAL_PURPOSE_INPUTS, SLAVE_ADDR_LOW,
         DESKEW_VALUE}));
      rd(psilc_pkg::REG_STATUS, {2'h0, k, x[9], x[12], x[13], x[14], x[15]});
   endtask
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // one pixel; junk edges carry inverted bus and controls
   task automatic pix(input int m, input logic keep);
      logic [23:0] d;
      logic de, h, v;
      lfsr = lfsr_step(lfsr);
      d = {lfsr, lfsr[7:0] ^ 8'hA5};
      {de, h, v} = lfsr[2:0];
      if (keep) exp_q.push_back({de, v, h, d});
      if (m == 1) psilc_gfx_src_inst.edge_out(1'b0, ~d, ~de, ~h, ~v);
      if (m < 2) psilc_gfx_src_inst.edge_out(1'b0, d, de, h, v);
      else begin
         psilc_gfx_src_inst.edge_out(1'b0, {~d[23:12], d[11:0]}, ~de, ~h, ~v);
         psilc_gfx_src_inst.edge_out(m == 3, {~d[11:0], d[23:12]}, de, h, v);
      end
      if (m == 0 || m == 3) psilc_gfx_src_inst.edge_out(1'b0, ~d, ~de, ~h, ~v);
      if (m == 3) psilc_gfx_src_inst.edge_out(1'b1, ~d, ~de, ~h, ~v);
   endtask
   always @(posedge CLK_SYS) begin
      if (WORD_VALID === 1'b1 && WORD_READY === 1'b1) begin
         if (exp_q.size() == 0) chk("extra word", 27'h0, 27'h1);
         else chk("word", exp_q.pop_front(), {WORD_DE, WORD_VSYNC, WORD_HSYNC, WORD_DATA});
      end
   end
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      mismatches++;
      $display("[ERR] run timeout");
      stop_test();
   end
   initial begin
      {RST, SERIAL_IF_SELECT, BUS_WIDTH_SELECT, DUAL_EDGE_SELECT, EDGE_SELECT} = 5'h10;
      {DESKEW_PIN_ENABLE, DESKEW_SETTING_PINS, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = 18'h0;
      WORD_READY = 1'b1;
      lfsr = 16'h005F;
      repeat (12) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (i = 0; i < 6; i++) begin
         cfg(tab[i]);
         if (i == 0) begin
            WORD_READY <= 1'b0;
            for (j = 0; j < 6; j++) pix(0, j < 5);
            rd(psilc_pkg::REG_FLAGS, 8'h01);
            wr(psilc_pkg::REG_FLAGS, 8'h01);
            rd(psilc_pkg::REG_FLAGS, 8'h00);
            @(posedge CLK_SYS);
            WORD_READY <= 1'b1;
         end
         if (i < 4) for (j = 0; j < 3; j++) pix(i, 1'b1);
         for (j = 0; j < 400 && exp_q.size() != 0; j++) @(posedge CLK_SYS);
         // let the last pop settle in the output stage
         @(posedge CLK_SYS);
         chk("left words", 27'h0, 27'(exp_q.size()));
         chk("drained", 27'h0, 27'(WORD_VALID));
         if (i == 4) begin
            rd(psilc_pkg::REG_MODE_CTRL, 8'h00);
            wr(psilc_pkg::REG_DESKEW_CTRL, 8'h05);
            wr(psilc_pkg::REG_MODE_CTRL, 8'h03);
            wr(psilc_pkg::REG_STATUS, 8'h00);
            wr(4'hF, 8'hFF);
            rd(psilc_pkg::REG_DESKEW_CTRL, 8'h05);
            rd(4'hF, 8'h00);
            rd(psilc_pkg::REG_STATUS, 8'h3B);
            chk("serial cfg", 27'h1D, 27'({MODE_24BIT, EDGE_RISING, DESKEW_VALUE}));
            wr(psilc_pkg::REG_MODE_CTRL, 8'h07);
            rd(psilc_pkg::REG_FLAGS, 8'h02);
         end
      end
      @(posedge CLK_SYS);
      SERIAL_IF_SELECT <= 1'b0;
      #1;
      chk("ctrl reset", 27'h0, 27'(SERIAL_CTRL_RESET_N));
      stop_test();
   end
endmodule
